/* verif/tb_top.sv */
// Self-checking testbench of the two-stage watchdog.
`timescale 1ns/10ps
module tb_top
    import wdt_pkg::*;
;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic        dbg_halt  = 1'b0;
    wdt_bus_t    bus       = '0;
    logic        irq;
    logic        sys_reset;
    logic [31:0] rdata;
    logic [31:0] v;
    logic [31:0] v2;
    logic        hit;
    int          errors      = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    // Reset values of every register, then an unmapped place.
    logic [39:0] rows [10] = '{{WDT_LOAD_OFS, WDT_LOAD_RESET}, {WDT_VALUE_OFS, WDT_LOAD_RESET},
        {WDT_CTRL_OFS, WDT_ZERO}, {WDT_ICLR_OFS, WDT_ZERO}, {WDT_RIS_OFS, WDT_ZERO}, {WDT_MIS_OFS, WDT_ZERO},
        {WDT_LOCK_OFS, WDT_ZERO}, {WDT_STATUS_OFS, WDT_ZERO}, {WDT_INTEN_OFS, WDT_ZERO}, {8'h24, WDT_ZERO}};

    wdt_top DUT (.clk(clk), .rst(rst), .bus(bus), .dbg_halt(dbg_halt), .rdata(rdata), .irq(irq),
                 .sys_reset(sys_reset));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task chkb(input logic b);
        chk({31'h0000_0000, b}, WDT_ONE);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: WDT_ZERO, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, v);
        chk(v, e);
    endtask
    // Polls the interrupt (sel 0) or the system reset (sel 1) for a bounded time.
    task wait_sig(input logic sel, input int n);
        hit = 1'b0;
        for (int i = 0; i < n && hit !== 1'b1; i++)
        begin
            @(posedge clk);
            #1 hit = (sel ? sys_reset : irq) === 1'b1;
        end
    endtask
    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        bus <= '0;
        dbg_halt <= 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask
    task final_report;
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            final_report;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        do_reset;
        foreach (rows[i]) rchk(rows[i][39:32], rows[i][31:0]);
        wr(WDT_LOAD_OFS, 32'h0000_0014);
        rchk(WDT_LOAD_OFS, 32'h0000_0014);
        wr(WDT_CTRL_OFS, 32'h0000_0003);
        rchk(WDT_INTEN_OFS, WDT_ONE);
        rd(WDT_VALUE_OFS, v);
        chkb(v < 32'h0000_0014 && v > 32'h0000_000A);
        wait_sig(1'b0, 40);
        chkb(hit);
        rchk(WDT_RIS_OFS, WDT_ONE);
        rchk(WDT_MIS_OFS, WDT_ONE);
        rd(WDT_VALUE_OFS, v);
        chkb(v <= 32'h0000_0014 && v > 32'h0000_0008);
        wait_sig(1'b1, 40);
        chkb(hit);
        rchk(WDT_STATUS_OFS, WDT_ONE);
        // Reset disabled: the clear reloads and no system reset follows.
        do_reset;
        wr(WDT_LOAD_OFS, 32'h0000_001E);
        wr(WDT_CTRL_OFS, WDT_ONE);
        wait_sig(1'b0, 60);
        chkb(hit);
        wr(WDT_ICLR_OFS, WDT_ZERO);
        rchk(WDT_RIS_OFS, WDT_ZERO);
        chkb(irq === 1'b0);
        rd(WDT_VALUE_OFS, v);
        chkb(v <= 32'h0000_001E && v > 32'h0000_0014);
        wait_sig(1'b1, 80);
        chkb(hit === 1'b0);
        wr(WDT_LOAD_OFS, 32'h0000_03E8);
        rd(WDT_VALUE_OFS, v);
        chkb(v <= 32'h0000_03E8 && v > 32'h0000_03DE);
        wr(WDT_LOCK_OFS, WDT_ZERO);
        rchk(WDT_LOCK_OFS, WDT_ONE);
        wr(WDT_LOAD_OFS, 32'h0000_0007);
        rchk(WDT_LOAD_OFS, 32'h0000_03E8);
        wr(WDT_CTRL_OFS, 32'h0000_0005);
        @(posedge clk) dbg_halt <= 1'b1;
        rd(WDT_VALUE_OFS, v);
        rd(WDT_VALUE_OFS, v2);
        chkb(v2 < v);
        wr(WDT_LOCK_OFS, WDT_UNLOCK_KEY);
        rchk(WDT_LOCK_OFS, WDT_ZERO);
        wr(WDT_CTRL_OFS, 32'h0000_0005);
        rd(WDT_VALUE_OFS, v);
        rd(WDT_VALUE_OFS, v2);
        chk(v2, v);
        @(posedge clk) dbg_halt <= 1'b0;
        rd(WDT_VALUE_OFS, v2);
        chkb(v2 < v);
        // A zero load value raises the interrupt source while stopped.
        do_reset;
        wr(WDT_LOAD_OFS, WDT_ZERO);
        rchk(WDT_RIS_OFS, WDT_ONE);
        rchk(WDT_MIS_OFS, WDT_ZERO);
        wr(WDT_INTEN_OFS, WDT_ONE);
        wait_sig(1'b0, 3);
        chkb(hit);
        final_report;
    end
endmodule // tb_top

/* verilog/wdt_pkg.sv */
// Package with register map, field positions and reset values of the two-stage watchdog.
package wdt_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] WDT_LOAD_OFS   = 8'h00;
    localparam logic [7:0] WDT_VALUE_OFS  = 8'h04;
    localparam logic [7:0] WDT_CTRL_OFS   = 8'h08;
    localparam logic [7:0] WDT_ICLR_OFS   = 8'h0C;
    localparam logic [7:0] WDT_RIS_OFS    = 8'h10;
    localparam logic [7:0] WDT_MIS_OFS    = 8'h14;
    localparam logic [7:0] WDT_LOCK_OFS   = 8'h18;
    localparam logic [7:0] WDT_STATUS_OFS = 8'h1C;
    localparam logic [7:0] WDT_INTEN_OFS  = 8'h20;

    // ------------------------------------------------------------
    // Field positions of the control register
    // ------------------------------------------------------------
    localparam int WDT_CTRL_RUN_BIT   = 0;
    localparam int WDT_CTRL_RESET_BIT = 1;
    localparam int WDT_CTRL_STALL_BIT = 2;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [31:0] WDT_UNLOCK_KEY  = 32'h1ACC_E551;
    localparam logic [31:0] WDT_LOAD_RESET  = 32'hFFFF_FFFF;
    localparam logic [31:0] WDT_ZERO        = 32'h0000_0000;
    localparam logic [31:0] WDT_ONE         = 32'h0000_0001;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } wdt_bus_t;

    typedef enum logic [1:0] {
        WDT_IDLE   = 2'b00,
        WDT_ARMED  = 2'b01,
        WDT_FIRED  = 2'b10
    } wdt_state_t;

endpackage

/* verilog/wdt_top.sv */
// Two-stage watchdog timer with register port and interrupt output.
`timescale 1ns/10ps
module wdt_top
    import wdt_pkg::*;
(
    input  wire logic        clk,       // System clock.
    input  wire logic        rst,       // Asynchronous reset, active high.
    input  wire wdt_bus_t    bus,       // Register request.
    input  wire logic        dbg_halt,  // Processor halted by debugger.
    output logic      [31:0] rdata,     // Read data, one cycle after read.
    output logic             irq,       // Interrupt level.
    output logic             sys_reset  // System reset, sticky until rst.
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] load_val;
    logic [31:0] count;
    logic        run;
    logic        int_en;
    logic        reset_en;
    logic        stall_en;
    logic        locked;
    logic        raw_int;
    wdt_state_t  state;

    logic        wr_load;
    logic        wr_ctrl;
    logic        wr_inten;
    logic        wr_clr;
    logic        wr_lock;
    logic        tick;
    logic        at_zero;
    logic        set_int;
    logic        next_irq;
    logic        next_raw_int;
    logic        next_int_en;
    logic        fire;

    assign wr_load  = bus.wr && bus.addr == WDT_LOAD_OFS && !locked;
    assign wr_ctrl  = bus.wr && bus.addr == WDT_CTRL_OFS && !locked;
    assign wr_inten = bus.wr && bus.addr == WDT_INTEN_OFS && !locked;
    assign wr_clr   = bus.wr && bus.addr == WDT_ICLR_OFS;
    assign wr_lock  = bus.wr && bus.addr == WDT_LOCK_OFS;
    assign tick     = run && !(stall_en && dbg_halt);
    assign at_zero  = tick && count == WDT_ZERO && !wr_load;
    // A zero load value fires immediately, even before counting starts.
    assign set_int  = at_zero || (wr_load && bus.wdata == WDT_ZERO);
    // A clear only wins against a source that is not setting again.
    assign next_raw_int = set_int || (raw_int && !wr_clr);
    assign next_int_en  = int_en || (wr_ctrl && bus.wdata[WDT_CTRL_RUN_BIT]) || (wr_inten && bus.wdata[0]);
    // The output follows the next masked status, so it never lags the status bits by a cycle.
    assign next_irq = next_raw_int && next_int_en;
    // A clear in the same cycle as the zero counts as servicing in time.
    assign fire     = at_zero && raw_int && reset_en && !wr_clr;

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            load_val <= WDT_LOAD_RESET;
            run      <= 1'b0;
            reset_en <= 1'b0;
            stall_en <= 1'b0;
            int_en   <= 1'b0;
        end
        else
        begin
            if (wr_load)
                load_val <= bus.wdata;
            if (wr_ctrl)
            begin
                // Enable is sticky: only reset stops a running watchdog.
                run      <= run | bus.wdata[WDT_CTRL_RUN_BIT];
                reset_en <= bus.wdata[WDT_CTRL_RESET_BIT];
                stall_en <= bus.wdata[WDT_CTRL_STALL_BIT];
                if (bus.wdata[WDT_CTRL_RUN_BIT])
                    int_en <= 1'b1;
            end
            else if (wr_inten && bus.wdata[0])
                int_en <= 1'b1;
        end
    end

    en_arms_a: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && bus.wdata[WDT_CTRL_RUN_BIT])
        |=> (run && int_en))
        else $error("enable did not arm");

    run_hold_a: assert property (@(posedge clk) disable iff (rst)
        run
        |=> run)
        else $error("running watchdog stopped");

    rst_en_wr_a: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl
        |=> reset_en == $past(bus.wdata[WDT_CTRL_RESET_BIT]))
        else $error("reset enable write lost");

    stall_wr_a: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl
        |=> stall_en == $past(bus.wdata[WDT_CTRL_STALL_BIT]))
        else $error("stall enable write lost");

    inten_set_a: assert property (@(posedge clk) disable iff (rst)
        (wr_inten && bus.wdata[0])
        |=> int_en)
        else $error("interrupt enable write lost");

    lock_hold_a: assert property (@(posedge clk) disable iff (rst)
        (bus.wr && locked && bus.addr == WDT_LOAD_OFS)
        |=> $stable(load_val))
        else $error("locked write took");

    lock_ctrl_a: assert property (@(posedge clk) disable iff (rst)
        (bus.wr && locked && bus.addr == WDT_CTRL_OFS)
        |=> ($stable(run) && $stable(reset_en) && $stable(stall_en) && $stable(int_en)))
        else $error("locked control write took");

    lock_inten_a: assert property (@(posedge clk) disable iff (rst)
        (bus.wr && locked && bus.addr == WDT_INTEN_OFS)
        |=> $stable(int_en))
        else $error("locked enable write took");

    load_imm_a: assert property (@(posedge clk) disable iff (rst)
        wr_load
        |=> (count == $past(bus.wdata) && load_val == $past(bus.wdata)))
        else $error("load lost");

    // ------------------------------------------------------------
    // Lock
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            locked <= 1'b0;
        else if (wr_lock)
            locked <= (bus.wdata != WDT_UNLOCK_KEY);
    end

    lock_set_a: assert property (@(posedge clk) disable iff (rst)
        (wr_lock && bus.wdata != WDT_UNLOCK_KEY)
        |=> locked)
        else $error("lock write did not lock");

    unlock_a: assert property (@(posedge clk) disable iff (rst)
        (wr_lock && bus.wdata == WDT_UNLOCK_KEY)
        |=> !locked)
        else $error("key did not unlock");

    lock_keep_a: assert property (@(posedge clk) disable iff (rst)
        !wr_lock
        |=> $stable(locked))
        else $error("lock changed without write");

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count <= WDT_LOAD_RESET;
        else if (wr_load)
            count <= bus.wdata;
        else if (wr_ctrl && bus.wdata[WDT_CTRL_RUN_BIT] && !run)
            count <= load_val;
        else if (wr_clr && tick)
            count <= load_val;
        else if (at_zero)
            count <= load_val;
        else if (tick)
            count <= count - WDT_ONE;
    end

    reload_zero_a: assert property (@(posedge clk) disable iff (rst)
        at_zero
        |=> count == $past(load_val))
        else $error("no reload after zero");

    start_load_a: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && bus.wdata[WDT_CTRL_RUN_BIT] && !run)
        |=> count == $past(load_val))
        else $error("enable did not start from load value");

    clr_reload_a: assert property (@(posedge clk) disable iff (rst)
        (wr_clr && tick)
        |=> count == $past(load_val))
        else $error("clear did not reload");

    count_dec_a: assert property (@(posedge clk) disable iff (rst)
        (tick && count != WDT_ZERO && !bus.wr)
        |=> count == $past(count) - WDT_ONE)
        else $error("counter did not decrement");

    stall_a: assert property (@(posedge clk) disable iff (rst)
        (run && stall_en && dbg_halt && !bus.wr)
        |=> $stable(count))
        else $error("count moved in stall");

    idle_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!run && !bus.wr)
        |=> $stable(count))
        else $error("count moved while stopped");

    // ------------------------------------------------------------
    // Timeout sequencing and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            raw_int <= 1'b0;
            state   <= WDT_IDLE;
        end
        else
        begin
            // A new timeout in the clear cycle keeps the flag set.
            if (set_int)
                raw_int <= 1'b1;
            else if (wr_clr)
                raw_int <= 1'b0;
            case (state)
                WDT_IDLE:
                begin
                    if (fire)
                        state <= WDT_FIRED;
                    else if (run)
                        state <= WDT_ARMED;
                end
                WDT_ARMED:
                begin
                    if (fire)
                        state <= WDT_FIRED;
                end
                WDT_FIRED: state <= WDT_FIRED;
                default:   state <= WDT_IDLE;
            endcase
        end
    end

    int_first_a: assert property (@(posedge clk) disable iff (rst)
        at_zero
        |=> raw_int)
        else $error("timeout did not set interrupt");

    zero_load_a: assert property (@(posedge clk) disable iff (rst)
        (wr_load && bus.wdata == WDT_ZERO)
        |=> raw_int)
        else $error("zero load no interrupt");

    clr_int_a: assert property (@(posedge clk) disable iff (rst)
        (wr_clr && !set_int)
        |=> !raw_int)
        else $error("clear ignored");

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sys_reset <= 1'b0;
            irq       <= 1'b0;
        end
        else
        begin
            if (fire)
                sys_reset <= 1'b1;
            irq <= next_irq;
        end
    end

    second_rst_a: assert property (@(posedge clk) disable iff (rst)
        (at_zero && raw_int && reset_en && !wr_clr)
        |=> sys_reset)
        else $error("reset missed");

    no_rst_a: assert property (@(posedge clk) disable iff (rst)
        (!$past(reset_en) && !$past(sys_reset))
        |-> !sys_reset)
        else $error("reset while disabled");

    rst_hold_a: assert property (@(posedge clk) disable iff (rst)
        sys_reset
        |=> sys_reset)
        else $error("system reset dropped");

    fired_state_a: assert property (@(posedge clk) disable iff (rst)
        sys_reset == (state == WDT_FIRED))
        else $error("reset output and sequencer disagree");

    irq_mask_a: assert property (@(posedge clk) disable iff (rst)
        irq == (raw_int && int_en))
        else $error("irq not masked status");

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= WDT_ZERO;
        else if (bus.rd)
        begin
            case (bus.addr)
                WDT_LOAD_OFS:   rdata <= load_val;
                WDT_VALUE_OFS:  rdata <= count;
                WDT_CTRL_OFS:   rdata <= {29'h0000_0000, stall_en, reset_en, run};
                WDT_RIS_OFS:    rdata <= {31'h0000_0000, raw_int};
                WDT_MIS_OFS:    rdata <= {31'h0000_0000, raw_int && int_en};
                WDT_LOCK_OFS:   rdata <= {31'h0000_0000, locked};
                WDT_STATUS_OFS: rdata <= {31'h0000_0000, sys_reset};
                WDT_INTEN_OFS:  rdata <= {31'h0000_0000, int_en};
                default:        rdata <= WDT_ZERO;
            endcase
        end
        else
            rdata <= WDT_ZERO;
    end

    rd_load_a: assert property (@(posedge clk) disable iff (rst)
        (bus.rd && bus.addr == WDT_LOAD_OFS)
        |=> rdata == $past(load_val))
        else $error("load value read back wrong");

    rd_value_a: assert property (@(posedge clk) disable iff (rst)
        (bus.rd && bus.addr == WDT_VALUE_OFS)
        |=> rdata == $past(count))
        else $error("counter read back wrong");

    rd_status_a: assert property (@(posedge clk) disable iff (rst)
        (bus.rd && bus.addr == WDT_RIS_OFS)
        |=> rdata == {31'h0000_0000, $past(raw_int)})
        else $error("raw status read back wrong");

    rd_masked_a: assert property (@(posedge clk) disable iff (rst)
        (bus.rd && bus.addr == WDT_MIS_OFS)
        |=> rdata == {31'h0000_0000, $past(raw_int && int_en)})
        else $error("masked status read back wrong");

    rd_lock_a: assert property (@(posedge clk) disable iff (rst)
        (bus.rd && bus.addr == WDT_LOCK_OFS)
        |=> rdata == {31'h0000_0000, $past(locked)})
        else $error("lock state read back wrong");

endmodule // wdt_top
